// [core/cpmc_regs.vh]
// Constants for the counter panel mode controller: APB offsets, fields, resets, timing.
// Assumes inclusion by bare name from design files under core/.
`ifndef CPMC_REGS_VH
`define CPMC_REGS_VH
// ***************************************************************
// Register offsets (byte addresses)
// ***************************************************************
`define CPMC_OFF_KEY      12'h000
`define CPMC_OFF_STATUS   12'h004
`define CPMC_OFF_FUNC     12'h008
`define CPMC_OFF_CTRL     12'h00C
`define CPMC_OFF_TOTAL    12'h010
`define CPMC_OFF_ADDR     12'h014
`define CPMC_OFF_SETUP    12'h018
`define CPMC_OFF_EVENT    12'h01C
// ***************************************************************
// Key codes (KEY register bits 4:0)
// ***************************************************************
`define CPMC_KEY_DIGIT0   5'h00
`define CPMC_KEY_DIGIT9   5'h09
`define CPMC_KEY_POINT    5'h0A
`define CPMC_KEY_SIGN     5'h0B
`define CPMC_KEY_RECALL   5'h10
`define CPMC_KEY_STORE    5'h11
`define CPMC_KEY_LOCAL    5'h12
`define CPMC_KEY_RESET    5'h13
`define CPMC_KEY_INPUT    5'h14
`define CPMC_KEY_GATE     5'h15
`define CPMC_KEY_FUNC0    5'h18
`define CPMC_KEY_FUNC7    5'h1F
// ***************************************************************
// Function indices (one-hot position)
// ***************************************************************
`define CPMC_FN_FREQ1     3'h0
`define CPMC_FN_PERIOD    3'h1
`define CPMC_FN_RATIO     3'h2
`define CPMC_FN_PWIDTH    3'h3
`define CPMC_FN_FREQ2     3'h4
`define CPMC_FN_TI        3'h5
`define CPMC_FN_RISEFALL  3'h6
`define CPMC_FN_TIDELAY   3'h7
`define CPMC_FN_FREQ3     3'h7
// ***************************************************************
// Modes
// ***************************************************************
`define CPMC_MODE_MEAS    2'h0
`define CPMC_MODE_RECALL  2'h1
`define CPMC_MODE_ADDR    2'h2
`define CPMC_MODE_LEVEL   2'h3
// ***************************************************************
// Reset values and fields
// ***************************************************************
`define CPMC_RST_FUNC     8'h01
`define CPMC_RST_GATE_MS  17'h0012C
`define CPMC_RST_ADDR     5'h03
`define CPMC_ERR_CODE     8'h20
`define CPMC_PRESCALE     5'h14
`define CPMC_LVL_PW       7'h32
`define CPMC_LVL_LO       7'h0A
`define CPMC_LVL_HI       7'h5A
// Cycles per millisecond at 50 MHz
`define CPMC_CLK_HZ       50000000
`define CPMC_MS_CYCLES    (`CPMC_CLK_HZ / 1000)
`endif

// [core/cpmc_setup_mem.v]
// Setup memory: ten stored panel setups, one word each.
// Assumes writes come from the controller in the pclk domain.
`timescale 1ns/100ps
module cpmc_setup_mem #(
  parameter DEPTH = 10,
  parameter WIDTH = 32
) (
  // Clock
  input  wire             pclk,
  // Write port
  input  wire             wr_en,
  input  wire [3:0]       wr_idx,
  input  wire [WIDTH-1:0] wr_data,
  // Read port
  input  wire [3:0]       rd_idx,
  output wire [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  // Clocked write, not cleared at start of simulation; contents set only via writes
  always @(posedge pclk) begin
    if (wr_en && (wr_idx < DEPTH))
      mem_r[wr_idx] <= wr_data;
  end
  assign rd_data = (rd_idx < DEPTH) ? mem_r[rd_idx] : {WIDTH{1'b0}};
endmodule // cpmc_setup_mem

// [core/cpmc_panel_ctrl.v]
// Panel key interpreter for a universal counter, with APB register access.
// Assumes keys arrive as APB writes to KEY, one key per write, pclk at 50 MHz.
//
// Contract
// - Recall key enters recall entry, lights its indicator, flashes entry light.
// - In recall entry a digit loads that stored setup, then measuring resumes.
// - Loading a setup forces internal level control; knobs ignored until switched off.
// - Recall entry accepts recall, local and function/data keys; others show error 2.0.
// - Recall or local in recall entry leaves, restores mode, loads nothing.
// - Decimal point in recall entry shows bus address, enters address entry.
// - Address entry accepts store, recall, local, digits; local leaves address unchanged.
// - Sign key in recall entry shows level control setting; further presses toggle.
// - In level entry store commits shown value; local keeps previous value.
// - Level entry accepts store, recall, sign, local; others show error 2.0.
// - Function keys select one-hot functions; another function key, or a setup load with a nonzero function field copied as stored, replaces the active one.
// - Reset key starts new measurement, keeps function and all settings.
// - In recall entry function keys are ignored; in address and level entry they show error 2.0.
// - Power-up: channel-one frequency, 300 ms gate, auto trigger and attenuation on.
// - Period mode averages over as many periods as fit the gate time.
// - Ratio mode: gate time sets count of channel-two cycles accumulated.
// - Pulse width forces auto trigger at 50%; averaging adds digits.
// - Rise/fall forces common input and auto trigger at 10% and 90%.
// - Third-channel frequency is never selected (fn_f3 tied low): no divide by 20, channel one/two inputs stay on.
// - Delayed interval ignores stop events until gate delay expires.
// - Count begin counts channel-one events; reset or input key clears count.
// - Count hold freezes total; later count begin resumes from held total.
`timescale 1ns/100ps
`include "cpmc_regs.vh"
module cpmc_panel_ctrl (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Measurement engine events
  input  wire        ch1_event,
  input  wire        ch2_event,
  input  wire        start_event,
  input  wire        stop_event,
  // Measurement engine controls
  output reg         meas_restart_r,
  output reg         stop_enable_r,
  output reg  [31:0] periods_avg_r,
  output reg         ratio_done_r,
  output reg         interval_done_r,
  output wire        automatic_trigger,
  output wire        automatic_attenuation,
  output wire        common_input,
  output wire        ch12_input_off,
  output wire [4:0]  prescale_div,
  output wire [6:0]  trig_lo_pct,
  output wire [6:0]  trig_hi_pct,
  output wire        internal_level_control,
  output wire        extra_digits,
  // Panel indicators
  output wire        recall_lamp,
  output wire        entry_flash,
  output wire [7:0]  func_lamps,
  output wire [7:0]  error_code
);
  // ***************************************************************
  // State
  // ***************************************************************
  reg [1:0]  mode_r;
  reg [1:0]  saved_mode_r;
  reg [7:0]  func_r;
  reg [16:0] gate_ms_r;
  reg        automatic_trigger_r;
  reg        auto_att_r;
  reg        avg_r;
  reg        ilc_r;
  reg        ilc_shown_r;
  reg [4:0]  bus_addr_r;
  reg [4:0]  addr_edit_r;
  reg [7:0]  err_r;
  reg        counting_r;
  reg [31:0] total_r;
  reg [31:0] setup_data_r;
  reg [15:0] flash_div_r;
  reg        flash_r;
  reg [31:0] gate_cnt_r;
  reg [31:0] ratio_cnt_r;
  reg [31:0] ch1_acc_r;
  reg        ti_arm_r;
  // ***************************************************************
  // APB decode
  // ***************************************************************
  wire       wr  = psel & penable & pwrite;
  wire       key_wr = wr & (paddr == `CPMC_OFF_KEY);
  wire [4:0] key = pwdata[4:0];
  wire       is_digit = (key <= `CPMC_KEY_DIGIT9);
  wire       is_func  = (key >= `CPMC_KEY_FUNC0);
  wire       mapped = (paddr == `CPMC_OFF_KEY) | (paddr == `CPMC_OFF_STATUS) |
                      (paddr == `CPMC_OFF_FUNC) | (paddr == `CPMC_OFF_CTRL) |
                      (paddr == `CPMC_OFF_TOTAL) | (paddr == `CPMC_OFF_ADDR) |
                      (paddr == `CPMC_OFF_SETUP) | (paddr == `CPMC_OFF_EVENT);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  // Setup store port for stored panel setups
  wire        st_wr = wr & (paddr == `CPMC_OFF_SETUP);
  wire [31:0] mem_rd;
  cpmc_setup_mem #(.DEPTH(10), .WIDTH(32)) u_mem (
    .pclk    (pclk),
    .wr_en   (st_wr),
    .wr_idx  (pwdata[27:24]),
    .wr_data ({4'h0, 4'h0, pwdata[23:0]}),
    .rd_idx  (key[3:0]),
    .rd_data (mem_rd)
  );
  wire fn_pw = func_r[`CPMC_FN_PWIDTH];
  wire fn_rf = func_r[`CPMC_FN_RISEFALL];
  wire fn_f3 = 1'b0;
  wire gate_cycles_hit;
  // ***************************************************************
  // Key interpreter
  // ***************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r       <= `CPMC_MODE_MEAS;
      saved_mode_r <= `CPMC_MODE_MEAS;
      func_r       <= `CPMC_RST_FUNC;
      gate_ms_r    <= `CPMC_RST_GATE_MS;
      automatic_trigger_r  <= 1'b1;
      auto_att_r   <= 1'b1;
      avg_r        <= 1'b0;
      ilc_r        <= 1'b0;
      ilc_shown_r  <= 1'b0;
      bus_addr_r   <= `CPMC_RST_ADDR;
      addr_edit_r  <= `CPMC_RST_ADDR;
      err_r        <= 8'h00;
      meas_restart_r <= 1'b0;
    end else begin
      meas_restart_r <= 1'b0;
      if (wr && paddr == `CPMC_OFF_CTRL) begin
        gate_ms_r   <= pwdata[16:0];
        automatic_trigger_r <= pwdata[17];
        auto_att_r  <= pwdata[18];
        avg_r       <= pwdata[19];
      end
      if (key_wr) begin
        err_r <= 8'h00;
        case (mode_r)
          `CPMC_MODE_MEAS: begin
            if (key == `CPMC_KEY_RECALL) begin
              saved_mode_r <= mode_r;
              mode_r       <= `CPMC_MODE_RECALL;
            end else if (is_func) begin
              func_r <= 8'h01 << (key - `CPMC_KEY_FUNC0);
              meas_restart_r <= 1'b1;
            end else if (key == `CPMC_KEY_RESET) begin
              meas_restart_r <= 1'b1;
            end
          end
          `CPMC_MODE_RECALL: begin
            if (key == `CPMC_KEY_RECALL || key == `CPMC_KEY_LOCAL) begin
              mode_r <= saved_mode_r;
            end else if (is_digit) begin
              func_r      <= (mem_rd[7:0] == 8'h00) ? func_r : mem_rd[7:0];
              gate_ms_r   <= mem_rd[24:8];
              ilc_r       <= 1'b1;
              mode_r      <= saved_mode_r;
              meas_restart_r <= 1'b1;
            end else if (key == `CPMC_KEY_POINT) begin
              addr_edit_r <= bus_addr_r;
              mode_r      <= `CPMC_MODE_ADDR;
            end else if (key == `CPMC_KEY_SIGN) begin
              ilc_shown_r <= ilc_r;
              mode_r      <= `CPMC_MODE_LEVEL;
            end else if (!is_func) begin
              err_r <= `CPMC_ERR_CODE;
            end
          end
          `CPMC_MODE_ADDR: begin
            if (key == `CPMC_KEY_LOCAL || key == `CPMC_KEY_RECALL) begin
              mode_r <= saved_mode_r;
            end else if (key == `CPMC_KEY_STORE) begin
              bus_addr_r <= addr_edit_r;
              mode_r     <= saved_mode_r;
            end else if (is_digit) begin
              addr_edit_r <= (addr_edit_r * 5'h0A) + key;
            end else begin
              err_r <= `CPMC_ERR_CODE;
            end
          end
          `CPMC_MODE_LEVEL: begin
            if (key == `CPMC_KEY_SIGN) begin
              ilc_shown_r <= ~ilc_shown_r;
            end else if (key == `CPMC_KEY_STORE) begin
              ilc_r  <= ilc_shown_r;
              mode_r <= saved_mode_r;
            end else if (key == `CPMC_KEY_LOCAL || key == `CPMC_KEY_RECALL) begin
              mode_r <= saved_mode_r;
            end else begin
              err_r <= `CPMC_ERR_CODE;
            end
          end
          default: mode_r <= `CPMC_MODE_MEAS;
        endcase
      end
    end
  end
  // ***************************************************************
  // Totalizer
  // ***************************************************************
  wire in_meas = (mode_r == `CPMC_MODE_MEAS);
  wire clr_tot = key_wr & in_meas & ((key == `CPMC_KEY_RESET) | (key == `CPMC_KEY_INPUT));
  wire tot_go  = key_wr & in_meas & (key == `CPMC_KEY_FUNC0 + 5'h06);
  wire tot_hold = key_wr & in_meas & (key == `CPMC_KEY_FUNC0 + 5'h07);
  // Count begin / hold and clear of the running total
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      total_r    <= 32'h0000_0000;
      counting_r <= 1'b0;
    end else begin
      if (tot_go)
        counting_r <= 1'b1;
      else if (tot_hold)
        counting_r <= 1'b0;
      if (clr_tot)
        total_r <= 32'h0000_0000;
      else if (counting_r && ch1_event)
        total_r <= total_r + 32'h0000_0001;
    end
  end
  // ***************************************************************
  // Gate timing: period averaging, ratio and delayed stop enable
  // ***************************************************************
  wire [31:0] gate_cycles = gate_ms_r * `CPMC_MS_CYCLES;
  assign gate_cycles_hit = (gate_cnt_r >= gate_cycles);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_cnt_r      <= 32'h0000_0000;
      ratio_cnt_r     <= 32'h0000_0000;
      ch1_acc_r       <= 32'h0000_0000;
      periods_avg_r   <= 32'h0000_0000;
      ratio_done_r    <= 1'b0;
      interval_done_r <= 1'b0;
      stop_enable_r   <= 1'b0;
      ti_arm_r        <= 1'b0;
    end else begin
      ratio_done_r    <= 1'b0;
      interval_done_r <= 1'b0;
      if (meas_restart_r) begin
        gate_cnt_r  <= 32'h0000_0000;
        ratio_cnt_r <= 32'h0000_0000;
        ch1_acc_r   <= 32'h0000_0000;
        ti_arm_r    <= 1'b0;
        stop_enable_r <= 1'b0;
      end else begin
        gate_cnt_r <= gate_cycles_hit ? 32'h0000_0000 : gate_cnt_r + 32'h0000_0001;
        // Periods counted within one gate
        if (func_r[`CPMC_FN_PERIOD]) begin
          if (gate_cycles_hit) begin
            periods_avg_r <= ch1_acc_r;
            ch1_acc_r     <= 32'h0000_0000;
          end else if (ch1_event)
            ch1_acc_r <= ch1_acc_r + 32'h0000_0001;
        end
        // Ratio closes after gate-time count of channel-two cycles
        if (func_r[`CPMC_FN_RATIO] && ch2_event) begin
          if (ratio_cnt_r + 32'h0000_0001 >= {15'h0000, gate_ms_r}) begin
            ratio_cnt_r  <= 32'h0000_0000;
            ratio_done_r <= 1'b1;
          end else
            ratio_cnt_r <= ratio_cnt_r + 32'h0000_0001;
        end
        // Delayed interval: stop disabled until delay elapses after start
        if (func_r[`CPMC_FN_TIDELAY]) begin
          if (start_event && !ti_arm_r) begin
            ti_arm_r      <= 1'b1;
            gate_cnt_r    <= 32'h0000_0000;
            stop_enable_r <= 1'b0;
          end else if (ti_arm_r && gate_cycles_hit)
            stop_enable_r <= 1'b1;
          if (ti_arm_r && stop_enable_r && stop_event) begin
            interval_done_r <= 1'b1;
            ti_arm_r        <= 1'b0;
            stop_enable_r   <= 1'b0;
          end
        end else
          stop_enable_r <= 1'b1;
      end
    end
  end
  // ***************************************************************
  // Entry light flasher
  // ***************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_div_r <= 16'h0000;
      flash_r     <= 1'b0;
    end else begin
      flash_div_r <= flash_div_r + 16'h0001;
      if (flash_div_r == 16'hFFFF)
        flash_r <= ~flash_r;
    end
  end
  // ***************************************************************
  // Forced settings and indicators
  // ***************************************************************
  assign automatic_trigger     = automatic_trigger_r | fn_pw | fn_rf;
  assign common_input          = fn_rf;
  assign trig_lo_pct           = fn_pw ? `CPMC_LVL_PW : (fn_rf ? `CPMC_LVL_LO : 7'h00);
  assign trig_hi_pct           = fn_pw ? `CPMC_LVL_PW : (fn_rf ? `CPMC_LVL_HI : 7'h00);
  assign extra_digits          = fn_pw & avg_r;
  assign ch12_input_off        = fn_f3;
  assign prescale_div          = fn_f3 ? `CPMC_PRESCALE : 5'h01;
  assign automatic_attenuation = auto_att_r;
  assign internal_level_control = ilc_r;
  assign recall_lamp           = (mode_r == `CPMC_MODE_RECALL);
  assign entry_flash           = ~in_meas & flash_r;
  assign func_lamps            = func_r;
  assign error_code            = err_r;
  // ***************************************************************
  // APB read mux
  // ***************************************************************
  always @* begin
    case (paddr)
      `CPMC_OFF_STATUS: prdata = {16'h0000, err_r, 2'b00, ilc_shown_r, ilc_r,
                                  counting_r, 1'b0, mode_r};
      `CPMC_OFF_FUNC:   prdata = {24'h000000, func_r};
      `CPMC_OFF_CTRL:   prdata = {12'h000, avg_r, auto_att_r, automatic_trigger_r, gate_ms_r};
      `CPMC_OFF_TOTAL:  prdata = total_r;
      `CPMC_OFF_ADDR:   prdata = {22'h000000, addr_edit_r, bus_addr_r};
      `CPMC_OFF_EVENT:  prdata = periods_avg_r;
      default:          prdata = 32'h0000_0000;
    endcase
  end
endmodule // cpmc_panel_ctrl

// [tb/cpmc_panel_monitor.sv]
// Checker for the panel mode controller: key handling and forced settings.
// Assumes a bind onto cpmc_panel_ctrl and the single pclk domain.
`timescale 1ns/100ps
`include "cpmc_regs.vh"
module cpmc_panel_monitor (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Panel and engine outputs
  input wire logic        automatic_trigger,
  input wire logic        common_input,
  input wire logic [6:0]  trig_lo_pct,
  input wire logic [6:0]  trig_hi_pct,
  input wire logic        extra_digits,
  input wire logic        recall_lamp,
  input wire logic [7:0]  func_lamps,
  input wire logic [7:0]  error_code
);
  // ***************************************************************
  // Key decode and assertions
  // ***************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A key press is a completed write to the key register
  wire       key_wr = psel && penable && pwrite && (paddr == `CPMC_OFF_KEY);
  wire [4:0] key    = pwdata[4:0];
  wire       fn_key = key_wr && (key[4:3] == 2'b11);

  property p_err; key_wr && recall_lamp && key == `CPMC_KEY_GATE |=> error_code == 8'h20;
  endproperty
  a_err: assert property (p_err) else $error("no error code for dead key");
  property p_leave; key_wr && recall_lamp && (key == `CPMC_KEY_RECALL
    || key == `CPMC_KEY_LOCAL) |=> !recall_lamp; endproperty
  a_leave: assert property (p_leave) else $error("recall entry not left");
  property p_data; fn_key && recall_lamp |=> $stable(func_lamps) && recall_lamp; endproperty
  a_data: assert property (p_data) else $error("function key acted in entry");
  property p_onehot; $onehot(func_lamps); endproperty
  a_onehot: assert property (p_onehot) else $error("function lamps not one-hot");
  property p_keep; key_wr && key == `CPMC_KEY_RESET |=> $stable(func_lamps); endproperty
  a_keep: assert property (p_keep) else $error("reset key changed function");
  property p_pw; func_lamps[3] |-> automatic_trigger && trig_lo_pct == 7'h32
    && trig_hi_pct == 7'h32; endproperty
  a_pw: assert property (p_pw) else $error("pulse width trigger wrong");
  property p_rf; common_input |-> automatic_trigger && trig_lo_pct == 7'h0A
    && trig_hi_pct == 7'h5A; endproperty
  a_rf: assert property (p_rf) else $error("rise fall trigger wrong");
  property p_dig; extra_digits |-> func_lamps[3]; endproperty
  a_dig: assert property (p_dig) else $error("extra digits outside pulse width");
  property p_pwr; $rose(presetn) |-> func_lamps == 8'h01 && automatic_trigger; endproperty
  a_pwr: assert property (p_pwr) else $error("power-up defaults wrong");
endmodule // cpmc_panel_monitor

bind cpmc_panel_ctrl cpmc_panel_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .automatic_trigger(automatic_trigger), .common_input(common_input),
  .trig_lo_pct(trig_lo_pct), .trig_hi_pct(trig_hi_pct), .extra_digits(extra_digits),
  .recall_lamp(recall_lamp), .func_lamps(func_lamps), .error_code(error_code));

// [tb/cpmc_event_src.sv]
// Stand-in for the measurement engine: bursts of one-cycle channel pulses.
// Assumes one burst at a time, requested by the bench in the pclk domain.
`timescale 1ns/100ps
module cpmc_event_src (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Burst request
  input  wire logic       go,
  input  wire logic [1:0] lane,
  input  wire logic [7:0] cnt,
  input  wire logic [3:0] gap,
  // Pulses and status
  output logic      [3:0] ev,
  output logic            busy
);
  logic [7:0] left_r;
  logic [3:0] wait_r;
  logic [1:0] lane_r;
  // Emit cnt pulses on one lane, gap idle cycles apart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {left_r, wait_r, lane_r, ev} <= '0;
    end else begin
      ev <= 4'h0;
      if (go) begin
        {left_r, wait_r, lane_r} <= {cnt, 4'h0, lane};
      end else if (left_r != 8'h00) begin
        if (wait_r == 4'h0) begin
          ev[lane_r] <= 1'b1;
          {left_r, wait_r} <= {left_r - 8'h01, gap};
        end else begin
          wait_r <= wait_r - 4'h1;
        end
      end
    end
  end
  assign busy = go || (left_r != 8'h00) || (ev != 4'h0);
endmodule // cpmc_event_src

// [tb/counter_panel_mode_control_tb_top.sv]
// Self-checking bench for the panel mode controller, keys sent over APB.
// Assumes core/cpmc_panel_ctrl.v, the event source and the bound checker.
`timescale 1ns/100ps
`include "cpmc_regs.vh"
module counter_panel_mode_control_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, go, busy, slv;
  logic        pready, pslverr, meas_restart_r, stop_enable_r, ratio_done_r, interval_done_r;
  logic        automatic_trigger, automatic_attenuation, common_input, ch12_input_off;
  logic        internal_level_control, extra_digits, recall_lamp, entry_flash;
  logic [1:0]  lane;
  logic [3:0]  ev, gap;
  logic [4:0]  prescale_div;
  logic [6:0]  trig_lo_pct, trig_hi_pct;
  logic [7:0]  cnt, func_lamps, error_code;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, periods_avg_r, rdat;
  int          failures, samples_checked, ratio_seen;

  cpmc_panel_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ch1_event(ev[0]), .ch2_event(ev[1]), .start_event(ev[2]),
    .stop_event(ev[3]), .meas_restart_r(meas_restart_r), .stop_enable_r(stop_enable_r),
    .periods_avg_r(periods_avg_r), .ratio_done_r(ratio_done_r),
    .interval_done_r(interval_done_r), .automatic_trigger(automatic_trigger),
    .automatic_attenuation(automatic_attenuation), .common_input(common_input),
    .ch12_input_off(ch12_input_off), .prescale_div(prescale_div),
    .trig_lo_pct(trig_lo_pct), .trig_hi_pct(trig_hi_pct),
    .internal_level_control(internal_level_control), .extra_digits(extra_digits),
    .recall_lamp(recall_lamp), .entry_flash(entry_flash), .func_lamps(func_lamps),
    .error_code(error_code));
  cpmc_event_src u_src (.pclk(pclk), .presetn(presetn), .go(go), .lane(lane), .cnt(cnt),
    .gap(gap), .ev(ev), .busy(busy));

  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Count ratio-complete pulses
  always @(posedge pclk) if (ratio_done_r === 1'b1) ratio_seen <= ratio_seen + 1;

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic lim(input int n);
    if (n >= 200) begin
      failures++;
      end_sim();
    end
  endtask
  // One APB transfer, then an idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 200);
    lim(n);
    {rdat, slv} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  task automatic key(input logic [4:0] k);
    apb(1'b1, `CPMC_OFF_KEY, {27'h0, k});
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // Burst of c pulses on lane l, waits until the source is idle
  task automatic burst(input logic [1:0] l, input logic [7:0] c, input logic [3:0] g);
    int n;
    {lane, cnt, gap, go} <= {l, c, g, 1'b1};
    @(posedge pclk);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (busy === 1'b1 && n < 200);
    lim(n);
    @(posedge pclk);
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_power();
    rd(`CPMC_OFF_FUNC);
    chk(rdat, 32'h1);
    rd(`CPMC_OFF_CTRL);
    chk(rdat, 32'h0006012C);
    chk({automatic_trigger, automatic_attenuation, internal_level_control}, 3'b110);
    rd(12'h020);
    chk(slv, 1'b1);
  endtask
  task automatic t_recall();
    apb(1'b1, `CPMC_OFF_SETUP, 32'h04000104);
    key(`CPMC_KEY_RECALL);
    chk(recall_lamp, 1'b1);
    key(`CPMC_KEY_GATE);
    chk(error_code, 8'h20);
    key(5'h04);
    rd(`CPMC_OFF_FUNC);
    chk(rdat, 32'h4);
    rd(`CPMC_OFF_STATUS);
    chk({rdat[4], rdat[1:0]}, 3'b100);
  endtask
  task automatic t_abort();
    key(`CPMC_KEY_RECALL);
    key(5'h19);
    key(`CPMC_KEY_LOCAL);
    rd(`CPMC_OFF_FUNC);
    chk(recall_lamp, 1'b0);
    chk(rdat, 32'h4);
    key(`CPMC_KEY_RECALL);
    key(`CPMC_KEY_RECALL);
    rd(`CPMC_OFF_STATUS);
    chk({recall_lamp, rdat[1:0]}, 3'b000);
  endtask
  task automatic t_addr();
    key(`CPMC_KEY_RECALL);
    key(`CPMC_KEY_POINT);
    rd(`CPMC_OFF_STATUS);
    chk(rdat[1:0], `CPMC_MODE_ADDR);
    key(`CPMC_KEY_SIGN);
    chk(error_code, 8'h20);
    key(5'h07);
    key(`CPMC_KEY_LOCAL);
    rd(`CPMC_OFF_ADDR);
    chk(rdat[4:0], 5'h03);
  endtask
  task automatic t_level();
    key(`CPMC_KEY_RECALL);
    key(`CPMC_KEY_SIGN);
    rd(`CPMC_OFF_STATUS);
    chk({rdat[5], rdat[1:0]}, 3'b111);
    key(`CPMC_KEY_SIGN);
    rd(`CPMC_OFF_STATUS);
    chk(rdat[5], 1'b0);
    key(5'h01);
    chk(error_code, 8'h20);
    key(`CPMC_KEY_STORE);
    chk(internal_level_control, 1'b0);
    key(`CPMC_KEY_RECALL);
    key(`CPMC_KEY_SIGN);
    key(`CPMC_KEY_SIGN);
    key(`CPMC_KEY_LOCAL);
    chk(internal_level_control, 1'b0);
  endtask
  task automatic t_funcs();
    for (int i = 0; i < 6; i++) begin
      key(`CPMC_KEY_FUNC0 + i[4:0]);
      chk(func_lamps, 8'h01 << i);
    end
    apb(1'b1, `CPMC_OFF_CTRL, 32'h000C012C);
    key(5'h1B);
    chk({extra_digits, automatic_trigger, trig_lo_pct, trig_hi_pct}, 16'hD932);
    key(`CPMC_KEY_RESET);
    chk(func_lamps, 8'h08);
  endtask
  task automatic t_count();
    int s;
    apb(1'b1, `CPMC_OFF_CTRL, 32'h00060003);
    key(5'h1A);
    s = ratio_seen;
    burst(2'd1, 8'd2, 4'd0);
    chk(ratio_seen - s, 32'h0);
    burst(2'd1, 8'd1, 4'd3);
    chk(ratio_seen - s, 32'h1);
    key(5'h1E);
    burst(2'd0, 8'd5, 4'd0);
    rd(`CPMC_OFF_TOTAL);
    chk(rdat, 32'h5);
    key(5'h1F);
    burst(2'd0, 8'd3, 4'd2);
    key(5'h1E);
    burst(2'd0, 8'd2, 4'd1);
    rd(`CPMC_OFF_TOTAL);
    chk(rdat, 32'h7);
    key(`CPMC_KEY_RESET);
    rd(`CPMC_OFF_TOTAL);
    chk(rdat, 32'h0);
    burst(2'd0, 8'd4, 4'd0);
    key(`CPMC_KEY_INPUT);
    rd(`CPMC_OFF_TOTAL);
    chk(rdat, 32'h0);
  endtask

  // Reset, then run every scenario
  initial begin
    {presetn, psel, penable, pwrite, go, paddr, pwdata, lane, cnt, gap} <= '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_power();
    t_recall();
    t_abort();
    t_addr();
    t_level();
    t_funcs();
    t_count();
    end_sim();
  end
endmodule // counter_panel_mode_control_tb_top
